// >>> rtl/ftpwm_cfg.svh
// Fast PWM timer: register indices, field positions, reset values, rates.
// Assumes a 40 MHz system clock; included by bare name from rtl/.
`ifndef FTPWM_CFG_SVH
`define FTPWM_CFG_SVH

// ------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ------------------------------------------------------------------
`define FTPWM_IDX_CTRL 6'h30
`define FTPWM_IDX_GEN 6'h2c
`define FTPWM_IDX_MASK 6'h39
`define FTPWM_IDX_FLAG 6'h38
`define FTPWM_IDX_CNT 6'h2f
`define FTPWM_IDX_CMPA 6'h2e
`define FTPWM_IDX_CMPB 6'h2b
`define FTPWM_IDX_TOP 6'h2d
`define FTPWM_IDX_PLL 6'h27

// ------------------------------------------------------------------
// Field positions
// ------------------------------------------------------------------
`define FTPWM_CTRL_CTC 7
`define FTPWM_CTRL_PWM 6
`define FTPWM_GEN_PWM 6
`define FTPWM_GEN_FORCE_B 3
`define FTPWM_GEN_FORCE_A 2
`define FTPWM_GEN_PSR 1
`define FTPWM_FLAG_CMPA 6
`define FTPWM_FLAG_CMPB 5
`define FTPWM_FLAG_OVF 2
`define FTPWM_FLAG_BITS 8'h64
`define FTPWM_PLL_LOW 7
`define FTPWM_PLL_ACE 2
`define FTPWM_PLL_EN 1
`define FTPWM_PLL_LOCK 0

// ------------------------------------------------------------------
// Reset values and rates
// ------------------------------------------------------------------
`define FTPWM_RST_BYTE 8'h00
`define FTPWM_RST_TOP 8'hff
`define FTPWM_CNT_MAX 8'hff
`define FTPWM_PCK_MHZ 64
`define FTPWM_PCK_LOW_MHZ 32
`define FTPWM_SYS_MHZ 40

`endif

// >>> rtl/ftpwm_pkg.sv
// Fast PWM timer: shared types.
// Assumes nothing beyond a SystemVerilog compiler.
package ftpwm_pkg;
   typedef logic [7:0] ftpwm_byte_t;
   typedef logic [1:0] ftpwm_mode_t;
   typedef logic [3:0] ftpwm_sel_t;
   typedef logic [13:0] ftpwm_presc_t;
endpackage : ftpwm_pkg

// >>> rtl/ftpwm_timer.sv
// Fast PWM timer: 8-bit counter, 14-bit prescaler, two compares,
// two complementary output pairs, classic Wishbone register slave.
// Assumes one 40 MHz clock; the fast peripheral clock arrives as a pin
// and is sampled, so its edge rate must stay below half the system clock.
`include "ftpwm_cfg.svh"

module ftpwm_timer
   import ftpwm_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic fast_peripheral_clock,
   input wire logic pll_lock_in,
   output logic output_a,
   output logic output_a_oe,
   output logic output_a_inv,
   output logic output_a_inv_oe,
   output logic output_b,
   output logic output_b_oe,
   output logic output_b_inv,
   output logic output_b_inv_oe,
   output logic timer_irq,
   output logic pll_enable,
   output logic low_speed_mode
);

   // ------------------------------------------------------------------
   // Prescaler tap decode
   // ------------------------------------------------------------------
   // Select 1 passes every base tick; select n waits for n-1 low ones
   function automatic logic presc_tap(input ftpwm_sel_t sel, input ftpwm_presc_t pc,
                                      input logic base);
      logic [14:0] m;
      m = (15'h0001 << (sel - 4'h1)) - 15'h0001;
      if (sel == 4'h0) begin
         return 1'b0;
      end
      return base && ((pc & m[13:0]) == m[13:0]);
   endfunction : presc_tap

   // ------------------------------------------------------------------
   // Register storage
   // ------------------------------------------------------------------
   ftpwm_byte_t timer_control_reg;
   logic [2:0] gen_bits;
   ftpwm_byte_t timer_mask_reg;
   ftpwm_byte_t timer_flag_reg;
   ftpwm_byte_t hold_a;
   ftpwm_byte_t hold_b;
   ftpwm_byte_t top_value;
   logic async_clock_enable;
   logic force_a;
   logic force_b;
   logic psr_pulse;

   // Bus decode
   logic req;
   logic wr;
   logic [5:0] idx;
   ftpwm_byte_t wdat;
   ftpwm_byte_t rd_byte;
   ftpwm_byte_t cnt_d1;
   ftpwm_byte_t cnt_d2;
   logic lock_s1;
   logic lock_s2;
   assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wr = req && wb_we_i && wb_sel_i[0];
   assign idx = wb_adr_i[7:2];
   assign wdat = wb_dat_i[7:0];

   // Read mux: control and compares straight from storage, counter delayed
   assign rd_byte =
      (idx == `FTPWM_IDX_CTRL) ? timer_control_reg :
      (idx == `FTPWM_IDX_GEN) ? {1'b0, gen_bits, 4'h0} :
      (idx == `FTPWM_IDX_MASK) ? timer_mask_reg :
      (idx == `FTPWM_IDX_FLAG) ? timer_flag_reg :
      (idx == `FTPWM_IDX_CNT) ? cnt_d2 :
      (idx == `FTPWM_IDX_CMPA) ? hold_a :
      (idx == `FTPWM_IDX_CMPB) ? hold_b :
      (idx == `FTPWM_IDX_TOP) ? top_value :
      (idx == `FTPWM_IDX_PLL) ? {low_speed_mode, 4'h0, async_clock_enable,
                                 pll_enable, lock_s2} :
      `FTPWM_RST_BYTE;

   // ------------------------------------------------------------------
   // Wishbone slave: one-cycle answer, unmapped reads return zero
   // ------------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (rst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= req;
         wb_dat_o <= req ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      end
   end

   // Software-written registers; strobe bits never store
   always_ff @(posedge clock) begin
      if (rst) begin
         timer_control_reg <= `FTPWM_RST_BYTE;
         gen_bits <= 3'h0;
         timer_mask_reg <= `FTPWM_RST_BYTE;
         top_value <= `FTPWM_RST_TOP;
         async_clock_enable <= 1'b0;
         pll_enable <= 1'b0;
         low_speed_mode <= 1'b0;
      end else if (wr) begin
         if (idx == `FTPWM_IDX_CTRL) timer_control_reg <= wdat;
         if (idx == `FTPWM_IDX_GEN) gen_bits <= wdat[6:4];
         if (idx == `FTPWM_IDX_MASK) timer_mask_reg <= wdat & `FTPWM_FLAG_BITS;
         if (idx == `FTPWM_IDX_TOP) top_value <= wdat;
         if (idx == `FTPWM_IDX_PLL) begin
            async_clock_enable <= wdat[`FTPWM_PLL_ACE];
            pll_enable <= wdat[`FTPWM_PLL_EN];
            low_speed_mode <= wdat[`FTPWM_PLL_LOW];
         end
      end
   end

   // Compare writes always land in holding; the active value follows later
   always_ff @(posedge clock) begin
      if (rst) begin
         hold_a <= `FTPWM_RST_BYTE;
         hold_b <= `FTPWM_RST_BYTE;
      end else begin
         if (wr && idx == `FTPWM_IDX_CMPA) hold_a <= wdat;
         if (wr && idx == `FTPWM_IDX_CMPB) hold_b <= wdat;
      end
   end

   // One-cycle strobes: force compare and prescaler reset
   logic wr_gen;
   assign wr_gen = wr && (idx == `FTPWM_IDX_GEN);
   always_ff @(posedge clock) begin
      if (rst) begin
         force_a <= 1'b0;
         force_b <= 1'b0;
         psr_pulse <= 1'b0;
      end else begin
         force_a <= wr_gen && wdat[`FTPWM_GEN_FORCE_A];
         force_b <= wr_gen && wdat[`FTPWM_GEN_FORCE_B];
         psr_pulse <= wr_gen && wdat[`FTPWM_GEN_PSR];
      end
   end

   // ------------------------------------------------------------------
   // Input synchronisation toward the counter logic
   // ------------------------------------------------------------------
   // Two stages mirror the real crossing so software sees the same latency
   localparam int CFG_W = 8 + 3 + 8 + 8 + 8 + 4;
   logic [CFG_W-1:0] cfg_now;
   logic [CFG_W-1:0] cfg_s1;
   logic [CFG_W-1:0] cfg_s2;
   assign cfg_now = {timer_control_reg, gen_bits, hold_a, hold_b, top_value,
                     async_clock_enable, force_a, force_b, psr_pulse};
   always_ff @(posedge clock) begin
      if (rst) begin
         cfg_s1 <= '0;
         cfg_s2 <= '0;
      end else begin
         cfg_s1 <= cfg_now;
         cfg_s2 <= cfg_s1;
      end
   end

   // Synchronised view of the configuration
   logic s_ctc;
   logic s_ace;
   logic s_psr;
   ftpwm_sel_t s_cs;
   ftpwm_byte_t s_top;
   logic [1:0] ch_pwm;
   logic [1:0] ch_force;
   ftpwm_mode_t ch_mode [2];
   ftpwm_byte_t ch_hold [2];
   assign s_ctc = cfg_s2[38];
   assign ch_pwm = {cfg_s2[30], cfg_s2[37]};
   assign ch_mode[0] = cfg_s2[36:35];
   assign s_cs = cfg_s2[34:31];
   assign ch_mode[1] = cfg_s2[29:28];
   assign ch_hold[0] = cfg_s2[27:20];
   assign ch_hold[1] = cfg_s2[19:12];
   assign s_top = cfg_s2[11:4];
   assign s_ace = cfg_s2[3];
   assign ch_force = {cfg_s2[1], cfg_s2[2]};
   assign s_psr = cfg_s2[0];

   // ------------------------------------------------------------------
   // Timebase and prescaler
   // ------------------------------------------------------------------
   // Fast clock pin: two stages, then an edge detect on the later stages
   logic fpc_s1;
   logic fpc_s2;
   logic fpc_s3;
   always_ff @(posedge clock) begin
      if (rst) begin
         fpc_s1 <= 1'b0;
         fpc_s2 <= 1'b0;
         fpc_s3 <= 1'b0;
         lock_s1 <= 1'b0;
         lock_s2 <= 1'b0;
      end else begin
         fpc_s1 <= fast_peripheral_clock;
         fpc_s2 <= fpc_s1;
         fpc_s3 <= fpc_s2;
         lock_s1 <= pll_lock_in;
         lock_s2 <= lock_s1;
      end
   end

   logic base_tick;
   logic tick;
   ftpwm_presc_t presc;
   assign base_tick = s_ace ? (fpc_s2 && !fpc_s3) : 1'b1;
   assign tick = presc_tap(s_cs, presc, base_tick) && !s_psr;

   always_ff @(posedge clock) begin
      if (rst || s_psr) begin
         presc <= '0;
      end else if (base_tick) begin
         presc <= presc + 14'h0001;
      end
   end

   // ------------------------------------------------------------------
   // Counter and compare events
   // ------------------------------------------------------------------
   ftpwm_byte_t cnt;
   ftpwm_byte_t next_cnt;
   ftpwm_byte_t ch_act [2];
   logic [1:0] ch_match;
   logic pwm_any;
   logic at_top;
   logic ovf_evt;
   assign pwm_any = |ch_pwm;
   assign at_top = (cnt == s_top);
   // PWM or clear-on-top restarts from zero after top, else free wrap
   assign next_cnt = ((s_ctc || pwm_any) && at_top) ? 8'h00 : cnt + 8'h01;
   assign ovf_evt = tick && ((cnt == `FTPWM_CNT_MAX) || (pwm_any && at_top));

   always_ff @(posedge clock) begin
      if (rst) begin
         cnt <= 8'h00;
      end else if (tick) begin
         cnt <= next_cnt;
      end
   end

   // Event delay, counter readback delay and flag register
   logic [2:0] evt_d1;
   logic [2:0] evt_d2;
   ftpwm_byte_t flag_set;
   ftpwm_byte_t flag_clr;
   assign flag_set = {1'b0, evt_d2[0], evt_d2[1], 2'b00, evt_d2[2], 2'b00};
   assign flag_clr = (wr && idx == `FTPWM_IDX_FLAG) ? (wdat & `FTPWM_FLAG_BITS) : 8'h00;
   always_ff @(posedge clock) begin
      if (rst) begin
         evt_d1 <= 3'h0;
         evt_d2 <= 3'h0;
         cnt_d1 <= 8'h00;
         cnt_d2 <= 8'h00;
         timer_flag_reg <= `FTPWM_RST_BYTE;
         timer_irq <= 1'b0;
      end else begin
         evt_d1 <= {ovf_evt, ch_match};
         evt_d2 <= evt_d1;
         cnt_d1 <= cnt;
         cnt_d2 <= cnt_d1;
         // Setting beats clearing so an event in the clear cycle survives
         timer_flag_reg <= (timer_flag_reg & ~flag_clr) | flag_set;
         timer_irq <= |(timer_flag_reg & timer_mask_reg);
      end
   end

   // ------------------------------------------------------------------
   // Output channels
   // ------------------------------------------------------------------
   logic [1:0] true_q;
   logic [1:0] inv_q;
   logic [1:0] oe_q;
   logic [1:0] inv_oe_q;

   for (genvar i = 0; i < 2; i++) begin : g_chan
      logic lvl;
      logic pwm_true;
      logic hit;
      logic norm_next;
      assign ch_match[i] = tick && (cnt == ch_act[i]);
      // Set at zero, cleared at match; mode 11 is the reverse polarity
      assign lvl = (ch_mode[i] == 2'b11) ? (cnt >= ch_act[i]) : (cnt < ch_act[i]);
      assign pwm_true = (ch_act[i] == 8'h00) ? (ch_mode[i] == 2'b11) :
                        (ch_act[i] == s_top) ? (ch_mode[i] != 2'b11) : lvl;
      // Forcing is ignored while the channel modulates
      assign hit = ch_match[i] || (ch_force[i] && !ch_pwm[i]);
      assign norm_next = (ch_mode[i] == 2'b01) ? !true_q[i] : ch_mode[i][0];

      // Active compare: latched at top in PWM, direct otherwise
      always_ff @(posedge clock) begin
         if (rst) begin
            ch_act[i] <= 8'h00;
         end else if (!ch_pwm[i]) begin
            ch_act[i] <= ch_hold[i];
         end else if (tick && at_top) begin
            ch_act[i] <= ch_hold[i];
         end
      end

      always_ff @(posedge clock) begin
         if (rst) begin
            true_q[i] <= 1'b0;
            inv_q[i] <= 1'b0;
            oe_q[i] <= 1'b0;
            inv_oe_q[i] <= 1'b0;
         end else if (ch_pwm[i]) begin
            true_q[i] <= pwm_true;
            inv_q[i] <= !pwm_true;
            oe_q[i] <= (ch_mode[i] != 2'b00);
            inv_oe_q[i] <= (ch_mode[i] == 2'b01);
         end else begin
            oe_q[i] <= (ch_mode[i] != 2'b00);
            inv_oe_q[i] <= 1'b0;
            if (hit && ch_mode[i] != 2'b00) true_q[i] <= norm_next;
         end
      end
   end

   assign output_a = true_q[0];
   assign output_a_oe = oe_q[0];
   assign output_a_inv = inv_q[0];
   assign output_a_inv_oe = inv_oe_q[0];
   assign output_b = true_q[1];
   assign output_b_oe = oe_q[1];
   assign output_b_inv = inv_q[1];
   assign output_b_inv_oe = inv_oe_q[1];

   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   property p_stop;
      (s_cs == 4'h0) |=> $stable(cnt);
   endproperty
   a_stop: assert property (p_stop) else $error("Counter moved while stopped");

   property p_sync_tick;
      (!s_ace && s_cs == 4'h1 && !s_psr) |-> tick;
   endproperty
   a_sync_tick: assert property (p_sync_tick) else $error("Undivided tick missing");

   property p_psr;
      s_psr |=> (presc == 14'h0000);
   endproperty
   a_psr: assert property (p_psr) else $error("Prescaler not cleared");

   property p_cfg_delay;
      (wr && idx == `FTPWM_IDX_CTRL) |-> ##3 (s_cs == $past(wb_dat_i[3:0], 3));
   endproperty
   a_cfg_delay: assert property (p_cfg_delay) else $error("Control not staged");

   property p_readback;
      (req && !wb_we_i && idx == `FTPWM_IDX_CMPA) |=> wb_ack_o && wb_dat_o[7:0] == hold_a;
   endproperty
   a_readback: assert property (p_readback) else $error("Compare readback wrong");

   property p_flag_delay;
      ovf_evt |-> ##3 timer_flag_reg[`FTPWM_FLAG_OVF];
   endproperty
   a_flag_delay: assert property (p_flag_delay) else $error("Overflow flag late");

   property p_wrap;
      (tick && cnt == `FTPWM_CNT_MAX) |=> (cnt == 8'h00);
   endproperty
   a_wrap: assert property (p_wrap) else $error("No wrap from all ones");

   property p_pwm_top;
      (tick && pwm_any && at_top) |=> (cnt == 8'h00);
   endproperty
   a_pwm_top: assert property (p_pwm_top) else $error("No restart after top");

   property p_inv_off;
      !ch_pwm[0] |=> !inv_oe_q[0];
   endproperty
   a_inv_off: assert property (p_inv_off) else $error("Inverted pin driven");

   property p_latch;
      (ch_pwm[0] && !(tick && at_top)) |=> (ch_act[0] == $past(ch_act[0]));
   endproperty
   a_latch: assert property (p_latch) else $error("Compare changed before top");

   property p_static;
      (ch_pwm[0] && ch_act[0] == 8'h00 && ch_mode[0] == 2'b10) |=> !true_q[0];
   endproperty
   a_static: assert property (p_static) else $error("Zero compare not low");

   property p_irq;
      (|(timer_flag_reg & timer_mask_reg)) |=> timer_irq;
   endproperty
   a_irq: assert property (p_irq) else $error("Interrupt not raised");

   c_overflow: cover property (ovf_evt ##3 timer_flag_reg[`FTPWM_FLAG_OVF]);
   c_pwm_edge: cover property (ch_pwm[0] && true_q[0] ##1 !true_q[0]);
   c_async_tick: cover property (s_ace && tick);
   c_flag_clear: cover property (|flag_clr);

endmodule : ftpwm_timer

// >>> dv/ftpwm_load.sv
// Model of the switching loads on both complementary output pairs.
// Assumes outputs are registered on clock and settle before the falling edge.
module ftpwm_load (
   input wire logic clock,
   input wire logic output_a,
   input wire logic output_a_oe,
   input wire logic output_a_inv,
   input wire logic output_a_inv_oe,
   input wire logic output_b,
   input wire logic output_b_oe,
   input wire logic output_b_inv,
   input wire logic output_b_inv_oe,
   output logic [7:0] overlap_count
);
   timeunit 1ns;
   timeprecision 1ps;
   // --------------------------------------------------------------
   // Shoot-through watch
   // --------------------------------------------------------------
   // With no dead time, a driven pair must always be exact opposites
   initial overlap_count = 8'h00;
   always @(negedge clock) begin
      if (output_a_oe && output_a_inv_oe && output_a_inv !== ~output_a) begin
         overlap_count <= overlap_count + 8'h01;
      end
      if (output_b_oe && output_b_inv_oe && output_b_inv !== ~output_b) begin
         overlap_count <= overlap_count + 8'h01;
      end
   end
endmodule : ftpwm_load

// >>> dv/fast_timer_with_dual_pwm_tb.sv
// Self-checking bench for the fast PWM timer over classic Wishbone.
// Assumes the design answers each request with a one-cycle ack.
`include "ftpwm_cfg.svh"
module fast_timer_with_dual_pwm_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [7:0] wb_adr_i, ovl;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, q;
   logic output_a, output_a_oe, output_a_inv, output_a_inv_oe;
   logic output_b, output_b_oe, output_b_inv, output_b_inv_oe;
   logic timer_irq, pll_enable, low_speed_mode, fpc, lock;
   int err_count, checked, hi, lo;
   // --------------------------------------------------------------
   // Design and load model
   // --------------------------------------------------------------
   // Fast clock and lock pins come from the bench for the asynchronous scenario
   ftpwm_timer ftpwm_timer_i (.clock(clock), .rst(rst), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .fast_peripheral_clock(fpc), .pll_lock_in(lock), .output_a(output_a),
      .output_a_oe(output_a_oe), .output_a_inv(output_a_inv),
      .output_a_inv_oe(output_a_inv_oe), .output_b(output_b), .output_b_oe(output_b_oe),
      .output_b_inv(output_b_inv), .output_b_inv_oe(output_b_inv_oe),
      .timer_irq(timer_irq), .pll_enable(pll_enable), .low_speed_mode(low_speed_mode));
   ftpwm_load ftpwm_load_i (.clock(clock), .output_a(output_a), .output_a_oe(output_a_oe),
      .output_a_inv(output_a_inv), .output_a_inv_oe(output_a_inv_oe),
      .output_b(output_b), .output_b_oe(output_b_oe), .output_b_inv(output_b_inv),
      .output_b_inv_oe(output_b_inv_oe), .overlap_count(ovl));
   // --------------------------------------------------------------
   // Clock, watchdog and shared tasks
   // --------------------------------------------------------------
   always #12.5 clock = ~clock;
   // Fast clock toggles every 4 cycles so the sampled pin never loses an edge
   always begin
      repeat (4) @(posedge clock);
      fpc <= ~fpc;
   end
   // Whole run is well under 3000 cycles; this only cuts a hang
   initial begin
      #(25 * 20000);
      err_count++;
      close_out();
   end
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   // One classic cycle; ack is sampled at a rising edge, then the request drops
   task automatic wb(input logic w, input logic [5:0] idx, input logic [7:0] d);
      int n;
      @(posedge clock);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= {idx, 2'b00};
      wb_dat_i <= {24'h000000, d};
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      q = wb_dat_o;
      if (n >= 50) err_count++;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
   endtask : wb
   task automatic wait_lvl(input logic v, output int n);
      n = 0;
      do begin
         @(negedge clock);
         n++;
      end while (output_a !== v && n < 5000);
      if (n >= 5000) err_count++;
   endtask : wait_lvl
   // High time and low time of one full period of the true A output
   task automatic measure();
      wait_lvl(1'b0, hi);
      wait_lvl(1'b1, hi);
      wait_lvl(1'b0, hi);
      wait_lvl(1'b1, lo);
   endtask : measure
   task automatic close_out();
      $display("Checks %0d, mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : close_out
   // --------------------------------------------------------------
   // Scenarios
   // --------------------------------------------------------------
   task automatic t_regs();
      wb(1'b0, `FTPWM_IDX_TOP, 8'h00);
      check(q, 32'h000000ff);
      wb(1'b1, `FTPWM_IDX_CMPA, 8'h5a);
      wb(1'b0, `FTPWM_IDX_CMPA, 8'h00);
      check(q, 32'h0000005a);
      wb(1'b1, `FTPWM_IDX_GEN, 8'h02);
      wb(1'b0, `FTPWM_IDX_GEN, 8'h00);
      check(q, 32'h00000000);
      wb(1'b0, 6'h00, 8'h00);
      check(q, 32'h00000000);
      $display("Register test done");
   endtask : t_regs
   task automatic t_pwm();
      wb(1'b1, `FTPWM_IDX_TOP, 8'h09);
      wb(1'b1, `FTPWM_IDX_CMPA, 8'h04);
      wb(1'b1, `FTPWM_IDX_CTRL, 8'h51);
      measure();
      check(hi, 4);
      check(hi + lo, 10);
      check(output_a_inv_oe, 1'b1);
      wb(1'b1, `FTPWM_IDX_CMPA, 8'h07);
      wb(1'b0, `FTPWM_IDX_CMPA, 8'h00);
      check(q, 32'h00000007);
      measure();
      measure();
      check(hi, 7);
      wb(1'b1, `FTPWM_IDX_CTRL, 8'h53);
      measure();
      measure();
      check(hi + lo, 40);
      $display("PWM test done");
   endtask : t_pwm
   task automatic t_flags();
      wb(1'b1, `FTPWM_IDX_MASK, 8'h04);
      wb(1'b1, `FTPWM_IDX_FLAG, 8'h64);
      repeat (100) @(posedge clock);
      wb(1'b0, `FTPWM_IDX_FLAG, 8'h00);
      check(q & 32'h44, 32'h00000044);
      check(timer_irq, 1'b1);
      wb(1'b1, `FTPWM_IDX_CTRL, 8'h50);
      repeat (5) @(posedge clock);
      wb(1'b1, `FTPWM_IDX_FLAG, 8'h64);
      repeat (4) @(posedge clock);
      check(timer_irq, 1'b0);
      // Normal mode with the full 8-bit range: overflow only on the wrap
      wb(1'b1, `FTPWM_IDX_TOP, 8'hff);
      wb(1'b1, `FTPWM_IDX_CTRL, 8'h11);
      repeat (4) @(posedge clock);
      check(output_a_inv_oe, 1'b0);
      repeat (270) @(posedge clock);
      wb(1'b0, `FTPWM_IDX_FLAG, 8'h00);
      check(q & 32'h04, 32'h00000004);
      check(ovl, 8'h00);
      $display("Flag test done");
   endtask : t_flags
   // PLL start, lock poll, then PWM on the sampled fast clock (8 cycles a tick)
   task automatic t_async();
      int n;
      wb(1'b1, `FTPWM_IDX_PLL, 8'h82);
      check(pll_enable, 1'b1);
      check(low_speed_mode, 1'b1);
      repeat (40) @(posedge clock);
      lock <= 1'b1;
      n = 0;
      do begin
         wb(1'b0, `FTPWM_IDX_PLL, 8'h00);
         n++;
      end while (q[`FTPWM_PLL_LOCK] !== 1'b1 && n < 20);
      check(q, 32'h00000083);
      wb(1'b1, `FTPWM_IDX_PLL, 8'h86);
      wb(1'b1, `FTPWM_IDX_TOP, 8'h09);
      wb(1'b1, `FTPWM_IDX_CMPA, 8'h04);
      wb(1'b1, `FTPWM_IDX_CMPB, 8'h09);
      wb(1'b1, `FTPWM_IDX_GEN, 8'h60);
      wb(1'b1, `FTPWM_IDX_CTRL, 8'h51);
      measure();
      measure();
      check(hi + lo, 80);
      check(hi, 32);
      check(output_b, 1'b1);
      check(output_b_inv_oe, 1'b0);
      check(ovl, 8'h00);
      $display("Async test done");
   endtask : t_async
   initial begin
      clock = 1'b0;
      rst = 1'b1;
      {wb_cyc_i, wb_stb_i, wb_we_i} = 3'b000;
      wb_adr_i = 8'h00;
      wb_sel_i = 4'h1;
      wb_dat_i = 32'h00000000;
      fpc = 1'b0;
      lock = 1'b0;
      err_count = 0;
      checked = 0;
      repeat (6) @(posedge clock);
      rst <= 1'b0;
      t_regs();
      t_pwm();
      t_flags();
      t_async();
      close_out();
   end
endmodule : fast_timer_with_dual_pwm_tb
